// >>> inc/irps_pkg.sv
`default_nettype none
package irps_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] CTRL_INDEX   = 12'h0CE;
    localparam logic [11:0] CTRL_ADDR    = {CTRL_INDEX[9:0], 2'b00};
    localparam logic [11:0] TXDATA_ADDR  = 12'h000;
    localparam logic [11:0] STATUS_ADDR  = 12'h004;
    localparam logic [7:0]  CTRL_RESET   = 8'h0F;
    localparam logic [7:0]  CTRL_WMASK   = 8'h7F;
    localparam int unsigned EN_BIT       = 6;
    localparam int unsigned PULSE_BIT    = 5;
    localparam int unsigned DIV_MSB      = 4;
    localparam int unsigned ST_DONE      = 0;
    localparam int unsigned ST_FULL      = 1;
    localparam int unsigned ST_EMPTY     = 2;
    localparam int unsigned ST_BUSY      = 3;
    // ==========================================================
    // timing counts
    localparam logic [1:0]  PULSE_PERIODS = 2'd3;
    localparam logic [3:0]  STOP_INDEX    = 4'h9;
    localparam logic [4:0]  RX_STRETCH    = 5'h0E;
    localparam int unsigned FIFO_DEPTH    = 32;
    localparam int unsigned DATA_W        = 8;
    typedef enum logic {
        IRPS_TX_IDLE = 1'b0,
        IRPS_TX_SEND = 1'b1
    } irps_tx_state_type;
    typedef enum logic [1:0] {
        IRPS_DEC_CTRL = 2'b00,
        IRPS_DEC_TX   = 2'b01,
        IRPS_DEC_ST   = 2'b10,
        IRPS_DEC_NONE = 2'b11
    } irps_dec_type;
endpackage : irps_pkg
`default_nettype wire

// >>> rtl/irps_fifo.sv
`default_nettype none
module irps_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             push, pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q[AW-1:0]] = in_data;
        end
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            mem_q <= mem_d;
        end
    end
endmodule : irps_fifo
`default_nettype wire

// >>> rtl/irps_refdiv.sv
`default_nettype none
module irps_refdiv (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       restart,
    input  wire logic [4:0] divisor,
    output logic            tick
);
    logic [4:0] cnt_q, cnt_d, last;

    // a zero divisor would wrap to divide by 32; treat it as divide by one
    assign last = (divisor == 5'h00) ? 5'h00 : divisor - 5'h01;
    assign tick = !restart && (cnt_q == last);

    always_comb begin
        cnt_d = (restart || tick) ? 5'h00 : cnt_q + 5'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : irps_refdiv
`default_nettype wire

// >>> rtl/irps_top.sv
// How it works
// R01 - enabled: each zero bit becomes one short high pin pulse, one bits none
// R02 - enabled: received pulses are stretched into low serial levels for the receiver
// R03 - reset leaves shaping off; only setting control bit 6 turns it on
// R04 - disabled: serial transmit and receive pass straight to and from the pins
// R05 - enabled: raw serial is cut off from the pins, shaper sits between
// R06 - control bit 5 picks fixed width (0) or 3/16 bit time (1)
// R07 - fixed width ignores baud rate; proportional width follows the bit time
// R08 - fixed mode times pulses with oscillator divided by the 5-bit divisor
// R09 - divisor field resets to 0F hex
// R10 - software keeps the divisor at 4 or more in fixed mode
// R11 - software keeps reference clock within 1.34 to 2.13 MHz, ideally 1.83
// R12 - suggested divisors 16h at 40, 0Dh at 24, 04h at 7.3728 MHz
// R13 - software uses the ten-bit asynchronous frame mode only
// R14 - software uses equal transmit and receive baud rates from one timer
// R15 - works from 1.2k up to 115.2k bit per second
// R16 - pulses no narrower than 1.41 us, at 115.2k no wider than 2.23 us
// R17 - frame is start, eight data, stop; done flag at tenth rollover
// R18 - fixed pulse lasts three reference periods from the zero bit start
`default_nettype none
module irps_top #(
    parameter int unsigned FIFO_DEPTH = irps_pkg::FIFO_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        baud16_tick,
    input  wire logic        uart_rx_pin,
    output logic             uart_tx_pin,
    output logic             uart_rx_to_serial,
    output logic             transmit_done_flag
);
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("transmit fifo needs at least two words");
    end

    // ==========================================================
    // apb slave
    function automatic irps_pkg::irps_dec_type decode(input logic [11:0] a);
        if (a == irps_pkg::CTRL_ADDR) begin
            decode = irps_pkg::IRPS_DEC_CTRL;
        end else if (a == irps_pkg::TXDATA_ADDR) begin
            decode = irps_pkg::IRPS_DEC_TX;
        end else if (a == irps_pkg::STATUS_ADDR) begin
            decode = irps_pkg::IRPS_DEC_ST;
        end else begin
            decode = irps_pkg::IRPS_DEC_NONE;
        end
    endfunction : decode

    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic        done_q, done_d;
    logic        commit, wr_ctrl, push, clr_done, set_done;
    logic        fifo_in_ready, fifo_out_valid, pop, tx_busy;
    logic [7:0]  fifo_out_data;
    logic        en, prop_mode;
    logic [4:0]  divisor;
    irps_pkg::irps_dec_type dec;

    assign dec       = decode(paddr);
    assign commit    = psel & penable & pready_q;
    assign wr_ctrl   = commit & pwrite & (dec == irps_pkg::IRPS_DEC_CTRL);
    assign push      = commit & pwrite & (dec == irps_pkg::IRPS_DEC_TX);
    assign clr_done  = commit & pwrite & (dec == irps_pkg::IRPS_DEC_ST) & pwdata[irps_pkg::ST_DONE];
    assign en        = ctrl_q[irps_pkg::EN_BIT];
    assign prop_mode = ctrl_q[irps_pkg::PULSE_BIT];
    assign divisor   = ctrl_q[irps_pkg::DIV_MSB:0];

    always_comb begin
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (psel && penable && !pready_q) begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            case (dec)
                irps_pkg::IRPS_DEC_CTRL: begin
                    prdata_d[7:0] = ctrl_q;
                end
                irps_pkg::IRPS_DEC_TX: begin
                    // a write to a full fifo waits here until a word drains
                    pready_d = !pwrite || fifo_in_ready;
                end
                irps_pkg::IRPS_DEC_ST: begin
                    prdata_d[irps_pkg::ST_DONE]  = done_q;
                    prdata_d[irps_pkg::ST_FULL]  = !fifo_in_ready;
                    prdata_d[irps_pkg::ST_EMPTY] = !fifo_out_valid;
                    prdata_d[irps_pkg::ST_BUSY]  = tx_busy;
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        ctrl_d = wr_ctrl ? (pwdata[7:0] & irps_pkg::CTRL_WMASK) : ctrl_q; // see R03
        done_d = set_done | (done_q & !clr_done);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q    <= irps_pkg::CTRL_RESET; // see R03 see R09
            done_q    <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q    <= ctrl_d;
            done_q    <= done_d;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign transmit_done_flag = done_q;

    irps_fifo #(
        .WIDTH (irps_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    // ==========================================================
    // frame transmitter
    irps_pkg::irps_tx_state_type st_q, st_d;
    logic [3:0] tick_q, tick_d, idx_q, idx_d;
    logic [8:0] shift_q, shift_d;
    logic       ser_q, ser_d, roll;

    assign roll    = baud16_tick && (tick_q == 4'hF);
    assign tx_busy = (st_q == irps_pkg::IRPS_TX_SEND);

    always_comb begin
        st_d     = st_q;
        idx_d    = idx_q;
        shift_d  = shift_q;
        ser_d    = ser_q;
        pop      = 1'b0;
        set_done = 1'b0;
        tick_d   = baud16_tick ? tick_q + 4'h1 : tick_q;
        if (roll) begin
            case (st_q)
                irps_pkg::IRPS_TX_IDLE, irps_pkg::IRPS_TX_SEND: begin
                    if (st_q == irps_pkg::IRPS_TX_IDLE || idx_q == irps_pkg::STOP_INDEX) begin
                        ser_d = 1'b1;
                        st_d  = irps_pkg::IRPS_TX_IDLE;
                        if (fifo_out_valid) begin
                            pop     = 1'b1;
                            shift_d = {1'b1, fifo_out_data};
                            ser_d   = 1'b0; // see R17
                            idx_d   = 4'h0;
                            st_d    = irps_pkg::IRPS_TX_SEND;
                        end
                    end else begin
                        ser_d    = shift_q[0];
                        shift_d  = {1'b1, shift_q[8:1]};
                        idx_d    = idx_q + 4'h1;
                        set_done = (idx_d == irps_pkg::STOP_INDEX); // see R17
                    end
                end
                default: begin
                    st_d = irps_pkg::IRPS_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= irps_pkg::IRPS_TX_IDLE;
            tick_q  <= 4'h0;
            idx_q   <= 4'h0;
            shift_q <= 9'h1FF;
            ser_q   <= 1'b1;
        end else begin
            st_q    <= st_d;
            tick_q  <= tick_d;
            idx_q   <= idx_d;
            shift_q <= shift_d;
            ser_q   <= ser_d;
        end
    end

    // ==========================================================
    // pulse shaper
    logic       ref_tick, width_tick, pulse_q, pulse_d, tx_pin_q, tx_pin_d;
    logic [1:0] pcnt_q, pcnt_d;

    // the divider restarts at each bit start so the width is exact, not jittered
    irps_refdiv u_refdiv (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (roll),
        .divisor (divisor),
        .tick    (ref_tick)
    );

    assign width_tick = prop_mode ? baud16_tick : ref_tick; // see R06 see R07 see R08

    always_comb begin
        pulse_d = pulse_q;
        pcnt_d  = pcnt_q;
        if (!en) begin
            pulse_d = 1'b0;
            pcnt_d  = 2'd0;
        end else if (roll) begin
            pulse_d = !ser_d; // see R01
            pcnt_d  = 2'd0;
        end else if (pulse_q && width_tick) begin
            pcnt_d = pcnt_q + 2'd1;
            if (pcnt_d == irps_pkg::PULSE_PERIODS) begin
                pulse_d = 1'b0; // see R18 see R16 see R15
            end
        end
        tx_pin_d = en ? pulse_q : ser_q; // see R04 see R05
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q  <= 1'b0;
            pcnt_q   <= 2'd0;
            tx_pin_q <= 1'b1;
        end else begin
            pulse_q  <= pulse_d;
            pcnt_q   <= pcnt_d;
            tx_pin_q <= tx_pin_d;
        end
    end

    assign uart_tx_pin = tx_pin_q;

    // ==========================================================
    // receive stretcher
    logic       s1_q, s2_q, s3_q, stab_q, stab_d, prev_q, rxo_q, rxo_d, rise;
    logic [4:0] str_q, str_d;

    assign rise = stab_q & !prev_q;

    always_comb begin
        stab_d = (s2_q == s3_q) ? s3_q : stab_q;
        str_d  = str_q;
        if (rise) begin
            str_d = irps_pkg::RX_STRETCH; // see R02
        end else if (baud16_tick && str_q != 5'h00) begin
            str_d = str_q - 5'h01;
        end
        rxo_d = en ? (str_q == 5'h00) : stab_q; // see R04 see R05
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            s3_q   <= 1'b1;
            stab_q <= 1'b1;
            prev_q <= 1'b1;
            str_q  <= 5'h00;
            rxo_q  <= 1'b1;
        end else begin
            s1_q   <= uart_rx_pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            stab_q <= stab_d;
            prev_q <= stab_q;
            str_q  <= str_d;
            rxo_q  <= rxo_d;
        end
    end

    assign uart_rx_to_serial = rxo_q;

    // ==========================================================
    // checks
    logic [7:0] pw_q;
    logic [7:0] div_eff;

    assign div_eff = (divisor == 5'h00) ? 8'h01 : {3'b000, divisor};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_q <= 8'h00;
        end else begin
            pw_q <= pulse_q ? pw_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_one_no_pulse;
        en && roll && ser_d |=> !pulse_q;
    endproperty
    a_one_no_pulse: assert property (p_one_no_pulse) else $error("pulse on a one bit"); // see R01

    property p_zero_pulse;
        en && roll && !ser_d |=> pulse_q ##1 tx_pin_q;
    endproperty
    a_zero_pulse: assert property (p_zero_pulse) else $error("zero bit gave no pin pulse"); // see R01

    property p_rx_stretch;
        en && rise |=> !rxo_d [*2];
    endproperty
    a_rx_stretch: assert property (p_rx_stretch) else $error("received pulse not stretched"); // see R02

    property p_en_by_write;
        $rose(en) |-> $past(wr_ctrl) && $past(pwdata[irps_pkg::EN_BIT]);
    endproperty
    a_en_by_write: assert property (p_en_by_write) else $error("enable set without a write"); // see R03

    property p_bypass_tx;
        !$past(en) |-> uart_tx_pin == $past(ser_q);
    endproperty
    a_bypass_tx: assert property (p_bypass_tx) else $error("disabled tx pin not raw serial"); // see R04

    property p_bypass_rx;
        !$past(en) |-> uart_rx_to_serial == $past(stab_q);
    endproperty
    a_bypass_rx: assert property (p_bypass_rx) else $error("disabled rx not raw pin"); // see R04

    property p_shaped_tx;
        $past(en) |-> uart_tx_pin == $past(pulse_q);
    endproperty
    a_shaped_tx: assert property (p_shaped_tx) else $error("enabled tx pin not shaped"); // see R05

    property p_fixed_width;
        $fell(pulse_q) && $past(en) && !$past(prop_mode) && !$past(roll) && $stable(divisor)
            |-> pw_q == 8'(3 * div_eff);
    endproperty
    a_fixed_width: assert property (p_fixed_width) else $error("fixed pulse width wrong"); // see R18

    property p_prop_end;
        en && prop_mode && pulse_q && !roll && baud16_tick && pcnt_q == 2'd2 |=> !pulse_q;
    endproperty
    a_prop_end: assert property (p_prop_end) else $error("proportional pulse too long"); // see R06

    property p_done_tenth;
        roll && tx_busy && idx_q == 4'h8 |=> done_q && idx_q == irps_pkg::STOP_INDEX;
    endproperty
    a_done_tenth: assert property (p_done_tenth) else $error("done flag not set at stop bit"); // see R17

    property p_ready_once;
        pready_q |=> !pready_q;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready held two cycles");

    c_fixed_pulse: cover property ($fell(pulse_q) && !prop_mode);
    c_prop_pulse: cover property ($fell(pulse_q) && prop_mode);
    c_rx_stretch: cover property (en && rise);
    c_fifo_full: cover property (psel && penable && !fifo_in_ready);
endmodule : irps_top
`default_nettype wire

// >>> test/irps_xcvr_model.sv
`default_nettype none
module irps_xcvr_model (
    input  wire logic pclk,
    input  wire logic tx_pin,
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_len;
    int pulse_cnt;
    int min_w;
    int max_w;
    // ==========================================================
    // emitter side: width of every high run on the shaped output
    task automatic clear();
        pulse_cnt = 0;
        min_w     = 1 << 20;
        max_w     = 0;
    endtask : clear
    initial begin
        rx_pin  = 1'b1;
        run_len = 0;
        clear();
    end
    always @(posedge pclk) begin
        if (tx_pin === 1'b1) begin
            run_len++;
        end else if (run_len != 0) begin
            pulse_cnt++;
            min_w   = (run_len < min_w) ? run_len : min_w;
            max_w   = (run_len > max_w) ? run_len : max_w;
            run_len = 0;
        end
    end
    // ==========================================================
    // detector side: optical idle is dark, wired idle is high
    task automatic set_idle(input logic ir);
        @(posedge pclk);
        rx_pin <= ~ir;
    endtask : set_idle
    task automatic send_frame(input logic [7:0] data, input logic ir, input int bit_cyc);
        logic [9:0] bits;
        bits = {1'b1, data, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge pclk);
            rx_pin <= ir ? ~bits[k] : bits[k];
            if (ir) begin
                repeat (bit_cyc * 3 / 16) @(posedge pclk);
                rx_pin <= 1'b0;
                repeat (bit_cyc - bit_cyc * 3 / 16 - 1) @(posedge pclk);
            end else begin
                repeat (bit_cyc - 1) @(posedge pclk);
            end
        end
    endtask : send_frame
endmodule : irps_xcvr_model
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        baud16_tick;
    logic        uart_rx_pin;
    logic        uart_tx_pin;
    logic        uart_rx_to_serial;
    logic        transmit_done_flag;
    logic [31:0] rd;
    logic        err;
    int          error_cnt;
    int          n_checks;
    int          tick_per;
    int          tick_cnt;

    irps_top #(.FIFO_DEPTH(32)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .baud16_tick(baud16_tick), .uart_rx_pin(uart_rx_pin), .uart_tx_pin(uart_tx_pin),
        .uart_rx_to_serial(uart_rx_to_serial), .transmit_done_flag(transmit_done_flag)
    );
    irps_xcvr_model ir (.pclk(pclk), .tx_pin(uart_tx_pin), .rx_pin(uart_rx_pin));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // baud source; a zero period stalls the far side completely
    always @(posedge pclk) begin
        tick_cnt    <= (tick_cnt + 1 >= tick_per) ? 0 : tick_cnt + 1;
        baud16_tick <= (tick_per != 0) && (tick_cnt == 0);
    end
    // ==========================================================
    // reporting
    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic hang(input string what);
        error_cnt++;
        $display("unexpected at %0t: %s timed out", $time, what);
        results();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // ==========================================================
    // apb master
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            hang("apb");
        end
    endtask : apb
    // ==========================================================
    // scenarios
    task automatic t_reset();
        apb(1'b0, irps_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000000F, "control after reset");
        apb(1'b0, irps_pkg::STATUS_ADDR, 32'h0);
        chk(rd, 32'h00000004, "status after reset");
        chk({30'h0, uart_tx_pin, uart_rx_to_serial}, 32'h3, "idle lines");
    endtask : t_reset
    task automatic t_regs();
        apb(1'b1, irps_pkg::CTRL_ADDR, 32'hFFFFFFFF);
        apb(1'b0, irps_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000007F, "control fields");
        apb(1'b1, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped write error");
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b1, irps_pkg::CTRL_ADDR, 32'h0000000F);
    endtask : t_regs
    task automatic t_tx_raw();
        logic [31:0] got;
        int          n;
        got      = 32'h0;
        tick_per = 4;
        apb(1'b1, irps_pkg::TXDATA_ADDR, 32'h000000A5);
        n = 0;
        while (uart_tx_pin !== 1'b0 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) begin
            hang("start bit");
        end
        repeat (32) @(posedge pclk);
        for (int k = 0; k < 10; k++) begin
            got[k] = uart_tx_pin;
            repeat (64) @(posedge pclk);
        end
        chk(got, {22'h0, 1'b1, 8'hA5, 1'b0}, "plain frame");
        chk({31'h0, transmit_done_flag}, 32'h1, "done flag");
        apb(1'b1, irps_pkg::STATUS_ADDR, 32'h1);
        apb(1'b0, irps_pkg::STATUS_ADDR, 32'h0);
        chk(rd & 32'h1, 32'h0, "done cleared");
    endtask : t_tx_raw
    task automatic t_tx_ir(input logic [7:0] ctrl, input int tper, input int width);
        int n;
        tick_per = tper;
        apb(1'b1, irps_pkg::CTRL_ADDR, {24'h0, ctrl});
        apb(1'b1, irps_pkg::STATUS_ADDR, 32'h1);
        ir.clear();
        apb(1'b1, irps_pkg::TXDATA_ADDR, 32'h00000055);
        n = 0;
        while (transmit_done_flag !== 1'b1 && n < 8000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 8000) begin
            hang("shaped frame");
        end
        chk(ir.pulse_cnt, 32'd5, "one pulse per zero bit");
        chk(ir.min_w, width, "narrowest pulse");
        chk(ir.max_w, width, "widest pulse");
    endtask : t_tx_ir
    task automatic t_rx(input logic [7:0] ctrl, input logic ir_on);
        logic [31:0] got;
        got      = 32'h0;
        tick_per = 8;
        apb(1'b1, irps_pkg::CTRL_ADDR, {24'h0, ctrl});
        ir.set_idle(ir_on);
        repeat (200) @(posedge pclk);
        fork
            ir.send_frame(8'h3C, ir_on, 128);
            begin
                repeat (65) @(posedge pclk);
                for (int k = 0; k < 10; k++) begin
                    got[k] = uart_rx_to_serial;
                    repeat (128) @(posedge pclk);
                end
            end
        join
        chk(got, {22'h0, 1'b1, 8'h3C, 1'b0}, "received levels");
        // back to a wired idle line, later idle checks expect a high receive level
        ir.set_idle(1'b0);
    endtask : t_rx
    task automatic t_fifo();
        int n;
        tick_per = 0;
        apb(1'b1, irps_pkg::CTRL_ADDR, 32'h0000000F);
        apb(1'b1, irps_pkg::STATUS_ADDR, 32'h1);
        for (int k = 0; k < 32; k++) begin
            apb(1'b1, irps_pkg::TXDATA_ADDR, k);
        end
        apb(1'b0, irps_pkg::STATUS_ADDR, 32'h0);
        chk(rd & 32'hF, 32'h2, "buffer full");
        tick_per = 1;
        n        = 0;
        do begin
            repeat (100) @(posedge pclk);
            apb(1'b0, irps_pkg::STATUS_ADDR, 32'h0);
            n++;
        end while ((rd & 32'hC) !== 32'h4 && n < 200);
        chk(rd & 32'hF, 32'h5, "buffer drained");
    endtask : t_fifo
    task automatic t_reset_mid();
        apb(1'b1, irps_pkg::CTRL_ADDR, 32'h0000006A);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
    endtask : t_reset_mid
    // ==========================================================
    // main sequence
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        baud16_tick = 1'b0;
        tick_per    = 4;
        tick_cnt    = 0;
        error_cnt   = 0;
        n_checks    = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_tx_raw();
        t_tx_ir(8'h4F, 4, 45);
        t_tx_ir(8'h4F, 8, 45);
        t_tx_ir(8'h44, 4, 12);
        t_tx_ir(8'h5B, 27, 81);
        t_tx_ir(8'h60, 4, 12);
        t_tx_ir(8'h60, 8, 24);
        t_rx(8'h0F, 1'b0);
        t_rx(8'h4F, 1'b1);
        t_fifo();
        t_reset_mid();
        results();
    end
endmodule : tb
`default_nettype wire
